// ### common/cssc_pkg.sv
// Purpose: Constants for the sense feedback strobe control block
// Assumes: mclk at 200 MHz
// Notes:   Times are kept in their own units; cycle counts derive from them
package cssc_pkg;

  localparam int unsigned CLK_MHZ            = 200;
  // Times in ns, then the lowest prescale divisor
  localparam int unsigned FALLBACK_PERIOD_NS = 6500000;
  localparam int unsigned OVERFLOW_PULSE_NS  = 100000;
  localparam int unsigned TURN_ON_DELAY_NS   = 10000;
  localparam int unsigned SENSE_SETTLE_NS    = 20000;
  localparam int unsigned PRESCALE_LOWEST    = 1024;

  localparam int unsigned FALLBACK_CYC  = FALLBACK_PERIOD_NS * CLK_MHZ / 1000;
  localparam int unsigned OVERFLOW_CYC  = OVERFLOW_PULSE_NS * CLK_MHZ / 1000;
  localparam int unsigned BLANK_CYC     = (TURN_ON_DELAY_NS + SENSE_SETTLE_NS) * CLK_MHZ / 1000;

  // Feedback selector codes
  localparam logic [2:0] SEL_TEMP = 3'h5;
  localparam logic [2:0] SEL_VPWR = 3'h6;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // Register map (word offsets as byte addresses)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_AVG    = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam logic [5:0]  CTRL_RESET    = 6'h07;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_VALID = 2'b01,
    MODE_NEXT  = 2'b10,
    MODE_MID   = 2'b11
  } cssc_mode_t;

  typedef enum logic [1:0] {
    OP_SLEEP  = 2'b00,
    OP_NORMAL = 2'b01,
    OP_FAIL   = 2'b10
  } cssc_op_t;

endpackage : cssc_pkg

// ### core/cssc_core.sv
// Purpose: Feedback multiplexer control and sample strobe generation
// Assumes: All inputs synchronous to mclk; PWM timing supplied per channel
// Notes:   Strobe pin is open drain: driven low only, released for high
// Notes on behaviour
// - Current feedback off during high overcurrent window, on in low threshold phase.
// - In PWM, current feedback only during the output's on time.
// - Averaging mode flips amplifier offset sign at each strobe rising edge.
// - Averaging enable: 0 disabled (default, forced in Fail), 1 enabled.
// - Averaging halves the channel's full-scale range and low overcurrent threshold.
// - Strobe only in Normal mode; behaviour depends on current or voltage selection.
// - Mode 00 keeps strobe high; mode 01 drives low while sense is valid.
// - Valid-window mode holds strobe high while multiplexer switches.
// - Mode 10: as valid mode, but high after mux change until next PWM cycle.
// - Mode 11: low from pulse midpoint to end; switching and pre-midpoint blanked.
// - Without PWM clock failure, no strobe pulses during high overcurrent window or PWM off phase.
// - Blank strobe for turn-on delay plus settling after mux change or offset flip.
// - Current selected with PWM clock failure: 50% strobe, 6.5 ms period.
// - 100% duty in modes 10/11: strobe low, 100 us high pulse at overflow.
// - Without PWM clock failure, no current trigger after output fault until output enabled again.
// - Voltage selected: 50% strobe with period base clock divided by 1024.
// - Voltage selected with PWM clock failure: fixed 6.5 ms 50% strobe.
// - Selector routes chosen output current, die temperature or supply voltage.
// - Feedback path disabled in Fail and Sleep, active only in Normal.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
module cssc_core #(
  parameter int unsigned CH           = 5,
  parameter int unsigned FALLBACK_CYC = cssc_pkg::FALLBACK_CYC,
  parameter int unsigned BLANK_CYC    = cssc_pkg::BLANK_CYC,
  parameter int unsigned OVERFLOW_CYC = cssc_pkg::OVERFLOW_CYC
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic [1:0]    op_mode,
  input  wire logic          pwm_base_tick,
  input  wire logic          pwm_clock_fail,
  input  wire logic          pwm_cycle_start,
  input  wire logic [CH-1:0] power_outputs,
  input  wire logic [CH-1:0] full_duty,
  input  wire logic [CH-1:0] pulse_midpoint,
  input  wire logic [CH-1:0] high_overcurrent_window,
  input  wire logic [CH-1:0] output_fault,
  input  wire logic [CH-1:0] output_enable_event,
  output logic      [2:0]    feedback_selector,
  output logic               sense_route_enable,
  output logic               sense_current_enable,
  output logic               offset_sign,
  output logic      [CH-1:0] averaging_sense_mode,
  output logic      [CH-1:0] half_full_scale_range,
  output logic      [CH-1:0] half_low_overcurrent_threshold,
  output logic               sample_strobe_o,
  output logic               sample_strobe_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [5:0]    ctrl;
  logic [5:0]    next_ctrl;
  logic [CH-1:0] avg_en;
  logic [CH-1:0] next_avg_en;
  logic          ack;
  logic          next_ack;
  logic [31:0]   next_readdata;
  logic          normal;
  logic          strobe_low;
  logic          strobe_q;
  logic [2:0]    sel;
  logic [1:0]    mode_bits;

  assign normal    = (op_mode == cssc_pkg::OP_NORMAL);
  assign sel       = ctrl[cssc_pkg::CTRL_SEL_LSB +: 3];
  assign mode_bits = ctrl[cssc_pkg::CTRL_MODE_LSB +: 2];

  function automatic logic is_current(input logic [2:0] s, input int unsigned n);
    is_current = (32'(s) < n);
  endfunction : is_current

  always_comb
  begin
    next_ctrl     = ctrl;
    next_avg_en   = avg_en;
    next_ack      = 1'b0;
    next_readdata = 32'h0;
    // Write lands only on the edge that sees waitrequest low
    if (avs_write && ack)
    begin
      case (avs_address)
        cssc_pkg::ADDR_CTRL: next_ctrl   = avs_writedata[5:0];
        cssc_pkg::ADDR_AVG:  next_avg_en = avs_writedata[CH-1:0];
        default:             next_ctrl   = ctrl;
      endcase
    end
    if ((avs_read || avs_write) && !ack)
    begin
      next_ack = 1'b1;
      if (!avs_write)
      begin
        case (avs_address)
          cssc_pkg::ADDR_CTRL:   next_readdata = {26'h0, ctrl};
          cssc_pkg::ADDR_AVG:    next_readdata = {{(32-CH){1'b0}}, avg_en};
          cssc_pkg::ADDR_STATUS: next_readdata = {29'h0, offset_sign, strobe_q, normal};
          default:               next_readdata = 32'h0;
        endcase
      end
    end
    // Fail mode forces averaging off
    if (op_mode == cssc_pkg::OP_FAIL)
    begin
      next_avg_en = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl         <= cssc_pkg::CTRL_RESET;
      avg_en       <= '0;
      ack          <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ctrl         <= next_ctrl;
      avg_en       <= next_avg_en;
      ack          <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  // One wait state: request accepted on the cycle ack is high
  assign avs_waitrequest = !ack;

  ////////////////////////////////////////////////////////////////////////////
  // Analog path control
  logic cur_sel;
  logic ch_on;
  logic ch_high_overcurrent_window;
  logic ch_full;
  logic ch_mid;
  logic ch_fault;
  logic ch_reen;

  assign cur_sel  = is_current(sel, CH);
  assign ch_on    = cur_sel ? power_outputs[sel] : 1'b0;
  assign ch_high_overcurrent_window  = cur_sel ? high_overcurrent_window[sel] : 1'b0;
  assign ch_full  = cur_sel ? full_duty[sel] : 1'b0;
  assign ch_mid   = cur_sel ? pulse_midpoint[sel] : 1'b0;
  assign ch_fault = cur_sel ? output_fault[sel] : 1'b0;
  assign ch_reen  = cur_sel ? output_enable_event[sel] : 1'b0;

  assign feedback_selector    = sel;
  assign sense_route_enable   = normal && (sel != cssc_pkg::SEL_NONE);
  assign sense_current_enable = sense_route_enable && cur_sel
                                && ch_on && !ch_high_overcurrent_window;
  assign averaging_sense_mode           = avg_en;
  assign half_full_scale_range          = avg_en;
  assign half_low_overcurrent_threshold = avg_en;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe sequencing state
  localparam int unsigned CW = $clog2(FALLBACK_CYC + 1);
  localparam int unsigned HW = $clog2(cssc_pkg::PRESCALE_LOWEST);

  logic [2:0]    sel_q;
  logic [2:0]    next_sel_q;
  logic [CW-1:0] blank_cnt;
  logic [CW-1:0] next_blank_cnt;
  logic [CW-1:0] fb_cnt;
  logic [CW-1:0] next_fb_cnt;
  logic [CW-1:0] ovf_cnt;
  logic [CW-1:0] next_ovf_cnt;
  logic [HW-1:0] div_cnt;
  logic [HW-1:0] next_div_cnt;
  logic          wait_cycle;
  logic          next_wait_cycle;
  logic          wait_mid;
  logic          next_wait_mid;
  logic          fault_hold;
  logic          next_fault_hold;
  logic          mid_seen;
  logic          next_mid_seen;
  logic          next_offset_sign;
  logic          next_strobe_q;
  logic          mux_change;
  logic          strobe_rise;

  assign mux_change  = (sel != sel_q);
  // Pin rises when last cycle's active strobe is released now
  assign strobe_rise = strobe_q && !strobe_low;

  always_comb
  begin
    next_sel_q       = sel;
    next_blank_cnt   = (blank_cnt != '0) ? blank_cnt - CW'(1) : blank_cnt;
    next_fb_cnt      = (fb_cnt >= CW'(FALLBACK_CYC - 1)) ? '0 : fb_cnt + CW'(1);
    next_div_cnt     = pwm_base_tick ? div_cnt + HW'(1) : div_cnt;
    next_ovf_cnt     = (ovf_cnt != '0) ? ovf_cnt - CW'(1) : ovf_cnt;
    next_wait_cycle  = wait_cycle;
    next_wait_mid    = wait_mid;
    next_fault_hold  = fault_hold;
    next_mid_seen    = mid_seen;
    next_offset_sign = offset_sign;
    next_strobe_q    = strobe_low;
    if (pwm_cycle_start)
    begin
      next_wait_cycle = 1'b0;
      next_mid_seen   = 1'b0;
      if (ch_full)
      begin
        next_ovf_cnt = CW'(OVERFLOW_CYC);
      end
    end
    // Mux change wins over a cycle start in the same cycle
    if (mux_change)
    begin
      next_blank_cnt  = CW'(BLANK_CYC);
      next_wait_cycle = 1'b1;
      next_wait_mid   = 1'b1;
    end
    if (ch_mid && !mux_change)
    begin
      next_mid_seen = 1'b1;
      if (blank_cnt == '0)
      begin
        next_wait_mid = 1'b0;
      end
    end
    if (!ch_on)
    begin
      next_mid_seen = 1'b0;
    end
    // Fault set wins over a re-enable in the same cycle
    if (ch_reen)
    begin
      next_fault_hold = 1'b0;
    end
    if (ch_fault)
    begin
      next_fault_hold = 1'b1;
    end
    // Offset flips as the open-drain strobe is released
    if (strobe_rise && (avg_en[sel] && cur_sel))
    begin
      next_offset_sign = !offset_sign;
      next_blank_cnt   = CW'(BLANK_CYC);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sel_q       <= cssc_pkg::SEL_NONE;
      blank_cnt   <= '0;
      fb_cnt      <= '0;
      div_cnt     <= '0;
      ovf_cnt     <= '0;
      wait_cycle  <= 1'b1;
      wait_mid    <= 1'b1;
      fault_hold  <= 1'b0;
      mid_seen    <= 1'b0;
      offset_sign <= 1'b0;
      strobe_q    <= 1'b0;
    end
    else
    begin
      sel_q       <= next_sel_q;
      blank_cnt   <= next_blank_cnt;
      fb_cnt      <= next_fb_cnt;
      div_cnt     <= next_div_cnt;
      ovf_cnt     <= next_ovf_cnt;
      wait_cycle  <= next_wait_cycle;
      wait_mid    <= next_wait_mid;
      fault_hold  <= next_fault_hold;
      mid_seen    <= next_mid_seen;
      offset_sign <= next_offset_sign;
      strobe_q    <= next_strobe_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decision
  logic fb_low;
  logic div_low;
  logic valid_win;
  logic blanked;
  logic full_win;

  // Low half of each period gives 50% duty
  assign fb_low    = (fb_cnt < CW'(FALLBACK_CYC / 2));
  assign div_low   = !div_cnt[HW-1];
  assign blanked   = mux_change || (blank_cnt != '0);
  assign valid_win = ch_on && !ch_high_overcurrent_window && !blanked;
  assign full_win  = valid_win && (ovf_cnt == '0);

  always_comb
  begin
    strobe_low = 1'b0;
    if (!normal)
    begin
      strobe_low = 1'b0;
    end
    else if (!cur_sel)
    begin
      if (sel == cssc_pkg::SEL_TEMP || sel == cssc_pkg::SEL_VPWR)
      begin
        strobe_low = pwm_clock_fail ? fb_low : div_low;
      end
    end
    else if (pwm_clock_fail)
    begin
      strobe_low = fb_low;
    end
    else if (fault_hold)
    begin
      strobe_low = 1'b0;
    end
    else
    begin
      case (cssc_pkg::cssc_mode_t'(mode_bits))
        cssc_pkg::MODE_OFF:   strobe_low = 1'b0;
        cssc_pkg::MODE_VALID: strobe_low = valid_win;
        cssc_pkg::MODE_NEXT:
          strobe_low = ch_full ? full_win && !wait_cycle
                               : valid_win && !wait_cycle;
        cssc_pkg::MODE_MID:
          strobe_low = ch_full ? full_win && !wait_mid
                               : valid_win && mid_seen && !wait_mid;
        default:              strobe_low = 1'b0;
      endcase
    end
  end

  // Open drain: enable only to pull low
  assign sample_strobe_o  = 1'b0;
  assign sample_strobe_oe = strobe_low;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  strobe_off_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (normal && cur_sel && !pwm_clock_fail && mode_bits == 2'b00) |-> !sample_strobe_oe)
    else $error("strobe active in off mode");
  strobe_normal_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !normal |-> !sample_strobe_oe)
    else $error("strobe active outside normal");
  blank_after_mux_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (normal && cur_sel && !pwm_clock_fail && mux_change)
    |-> !sample_strobe_oe ##1 !sample_strobe_oe)
    else $error("strobe not blanked after mux change");
  high_overcurrent_window_suppress_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cur_sel && !pwm_clock_fail && ch_high_overcurrent_window) |-> !sample_strobe_oe)
    else $error("strobe during high overcurrent window");
  fail_avg_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (op_mode == cssc_pkg::OP_FAIL) |=> (avg_en == '0))
    else $error("averaging not forced off in fail");
  offset_flip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (strobe_rise && cur_sel && avg_en[sel]) |=> (offset_sign != $past(offset_sign)))
    else $error("offset sign did not flip");
  fault_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch_fault && !pwm_clock_fail) |=> (!sample_strobe_oe || pwm_clock_fail || !cur_sel))
    else $error("strobe after fault");
  feedback_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sense_current_enable |-> (normal && ch_on && !ch_high_overcurrent_window))
    else $error("current feedback outside on phase");

endmodule : cssc_core

// ### tb/cssc_mcu_model.sv
// Purpose: Microcontroller that samples the sense pin on strobe activation
// Assumes: Strobe pin pulled up; active level is low
// Notes:   Counts samples and completed averaging pairs
module cssc_mcu_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        strobe_pin,
  input  wire logic        avg_on,
  output logic      [15:0] sample_cnt,
  output logic      [15:0] pair_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pin_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Sample on the falling pin edge, pair two when averaging
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_q      <= 1'h1;
      sample_cnt <= 16'h0000;
      pair_cnt   <= 16'h0000;
    end
    else
    begin
      pin_q <= strobe_pin;
      if (pin_q && !strobe_pin)
      begin
        sample_cnt <= sample_cnt + 16'h0001;
        if (avg_on && sample_cnt[0])
          pair_cnt <= pair_cnt + 16'h0001;
      end
    end
  end
endmodule : cssc_mcu_model

// ### tb/current_sense_sync_control_tb.sv
// Purpose: Self-checking bench for the sense strobe control block
// Assumes: Shortened counts; outputs sampled at the falling edge
// Notes:   Strobe active means the pin is pulled low (oe high)
`define CSSC_CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (e)); end end
module current_sense_sync_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned CH = 5;
  localparam int unsigned BL = 10;
  localparam int unsigned OV = 8;

  logic          mclk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [3:0]    avs_address   = 4'h0;
  logic [31:0]   avs_writedata = 32'h0;
  logic [1:0]    op_mode       = 2'h1;
  logic          pwm_base_tick = 1'h1, pwm_clock_fail = 1'h0, pwm_cycle_start = 1'h0;
  logic [CH-1:0] power_outputs = '0, full_duty = '0, pulse_midpoint = '0;
  logic [CH-1:0] high_overcurrent_window = '0, output_fault = '0, output_enable_event = '0;
  logic [31:0]   avs_readdata, rd_s, q;
  logic          avs_waitrequest, wt_s, oe_s, sense_route_enable, sense_current_enable;
  logic          offset_sign, sample_strobe_o, sample_strobe_oe, strobe_pin;
  logic [2:0]    feedback_selector;
  logic [CH-1:0] averaging_sense_mode, half_full_scale_range, half_low_overcurrent_threshold;
  logic [15:0]   sample_cnt, sc_s, pair_cnt;
  int            error_cnt = 0, n_checks = 0;

  cssc_core #(.CH(CH), .FALLBACK_CYC(200), .BLANK_CYC(BL), .OVERFLOW_CYC(OV)) DUT (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .op_mode(op_mode), .pwm_base_tick(pwm_base_tick),
    .pwm_clock_fail(pwm_clock_fail), .pwm_cycle_start(pwm_cycle_start),
    .power_outputs(power_outputs), .full_duty(full_duty), .pulse_midpoint(pulse_midpoint),
    .high_overcurrent_window(high_overcurrent_window), .output_fault(output_fault),
    .output_enable_event(output_enable_event), .feedback_selector(feedback_selector),
    .sense_route_enable(sense_route_enable), .sense_current_enable(sense_current_enable),
    .offset_sign(offset_sign), .averaging_sense_mode(averaging_sense_mode),
    .half_full_scale_range(half_full_scale_range),
    .half_low_overcurrent_threshold(half_low_overcurrent_threshold),
    .sample_strobe_o(sample_strobe_o), .sample_strobe_oe(sample_strobe_oe));

  // Pull-up holds the pin high whenever the block lets go
  assign strobe_pin = sample_strobe_oe ? sample_strobe_o : 1'h1;

  cssc_mcu_model MCU (.mclk(mclk), .rst_n(rst_n), .strobe_pin(strobe_pin),
    .avg_on(averaging_sense_mode[0]), .sample_cnt(sample_cnt), .pair_cnt(pair_cnt));

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  // Mid-cycle copies avoid races with the design's own edge updates
  always @(negedge mclk)
  begin
    wt_s <= avs_waitrequest;
    rd_s <= avs_readdata;
    oe_s <= sample_strobe_oe;
    sc_s <= sample_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask : step

  task automatic cnt(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge mclk);
      c += int'(oe_s === 1'h1);
    end
  endtask : cnt

  // Request held until the edge that closes a cycle with waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (n > 0 && wt_s === 1'h0)
        break;
    end
    q = rd_s;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge mclk);
    if (n == 40)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask : bus

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int c;
    int s0;
    int p0;
    logic off0;
    step(3);
    rst_n <= 1'h1;
    step(1);
    bus(0, cssc_pkg::ADDR_CTRL, 32'h0);
    `CSSC_CHK(q, 32'h7)
    bus(0, cssc_pkg::ADDR_AVG, 32'h0);
    `CSSC_CHK(q, 32'h0)
    bus(0, cssc_pkg::ADDR_STATUS, 32'h0);
    `CSSC_CHK(q, 32'h1)
    bus(0, 4'hC, 32'h0);
    `CSSC_CHK(q, 32'h0)
    `CSSC_CHK(oe_s, 1'h0)
    `CSSC_CHK(averaging_sense_mode, 5'h00)
    for (int s = 5; s < 7; s++)
    begin
      bus(1, cssc_pkg::ADDR_CTRL, 32'(s));
      step(20);
      `CSSC_CHK(feedback_selector, 3'(s))
      `CSSC_CHK(sense_route_enable, 1'h1)
      cnt(2048, c);
      `CSSC_CHK(c, 1024)
    end
    pwm_clock_fail <= 1'h1;
    power_outputs  <= 5'h01;
    for (int s = 0; s < 7; s += 6)
    begin
      bus(1, cssc_pkg::ADDR_CTRL, 32'h10 | 32'(s));
      step(250);
      s0 = int'(sc_s);
      cnt(400, c);
      `CSSC_CHK(c, 200)
      `CSSC_CHK(sc_s, 16'(s0 + 2))
    end
    pwm_clock_fail <= 1'h0;
    bus(1, cssc_pkg::ADDR_CTRL, 32'h00);
    step(30);
    cnt(20, c);
    `CSSC_CHK(c, 0)
    bus(1, cssc_pkg::ADDR_CTRL, 32'h11);
    step(30);
    cnt(20, c);
    `CSSC_CHK(c, 0)
    bus(1, cssc_pkg::ADDR_CTRL, 32'h10);
    `CSSC_CHK(oe_s, 1'h0)
    step(BL - 3);
    `CSSC_CHK(oe_s, 1'h0)
    step(10);
    cnt(10, c);
    `CSSC_CHK(c, 10)
    high_overcurrent_window <= 5'h01;
    step(3);
    `CSSC_CHK(sense_current_enable, 1'h0)
    cnt(10, c);
    `CSSC_CHK(c, 0)
    high_overcurrent_window <= 5'h00;
    step(BL + 10);
    `CSSC_CHK(sense_current_enable, 1'h1)
    power_outputs <= 5'h00;
    step(3);
    `CSSC_CHK(sense_current_enable, 1'h0)
    cnt(10, c);
    `CSSC_CHK(c, 0)
    power_outputs <= 5'h01;
    output_fault  <= 5'h01;
    step(1);
    output_fault <= 5'h00;
    step(BL + 10);
    cnt(10, c);
    `CSSC_CHK(c, 0)
    output_enable_event <= 5'h01;
    step(1);
    output_enable_event <= 5'h00;
    step(BL + 10);
    cnt(10, c);
    `CSSC_CHK(c, 10)
    op_mode <= 2'h0;
    step(3);
    `CSSC_CHK(oe_s, 1'h0)
    `CSSC_CHK(sense_route_enable, 1'h0)
    op_mode <= 2'h1;
    bus(1, cssc_pkg::ADDR_CTRL, 32'h21);
    bus(1, cssc_pkg::ADDR_CTRL, 32'h20);
    step(BL + 20);
    cnt(10, c);
    `CSSC_CHK(c, 0)
    pwm_cycle_start <= 1'h1;
    step(1);
    pwm_cycle_start <= 1'h0;
    step(BL + 10);
    cnt(10, c);
    `CSSC_CHK(c, 10)
    full_duty       <= 5'h01;
    pwm_cycle_start <= 1'h1;
    step(1);
    pwm_cycle_start <= 1'h0;
    step(2);
    `CSSC_CHK(oe_s, 1'h0)
    step(OV + 5);
    cnt(10, c);
    `CSSC_CHK(c, 10)
    full_duty <= 5'h00;
    bus(1, cssc_pkg::ADDR_CTRL, 32'h31);
    bus(1, cssc_pkg::ADDR_CTRL, 32'h30);
    step(BL + 20);
    cnt(10, c);
    `CSSC_CHK(c, 0)
    pulse_midpoint <= 5'h01;
    step(1);
    pulse_midpoint <= 5'h00;
    step(2);
    cnt(10, c);
    `CSSC_CHK(c, 10)
    bus(1, cssc_pkg::ADDR_AVG, 32'h01);
    bus(0, cssc_pkg::ADDR_AVG, 32'h0);
    `CSSC_CHK(q, 32'h01)
    `CSSC_CHK(averaging_sense_mode, 5'h01)
    `CSSC_CHK(half_full_scale_range, 5'h01)
    `CSSC_CHK(half_low_overcurrent_threshold, 5'h01)
    bus(1, cssc_pkg::ADDR_CTRL, 32'h10);
    step(BL + 10);
    off0 = offset_sign;
    power_outputs <= 5'h00;
    step(5);
    `CSSC_CHK(offset_sign, ~off0)
    p0 = int'(pair_cnt);
    s0 = int'(sc_s);
    repeat (2)
    begin
      power_outputs <= 5'h01;
      step(BL + 10);
      power_outputs <= 5'h00;
      step(BL + 10);
    end
    `CSSC_CHK(offset_sign, ~off0)
    `CSSC_CHK(sc_s, 16'(s0 + 2))
    `CSSC_CHK(pair_cnt, 16'(p0 + 1))
    op_mode <= 2'h2;
    step(3);
    `CSSC_CHK(averaging_sense_mode, 5'h00)
    report_and_stop();
  end
endmodule : current_sense_sync_control_tb
